// File: irs_cmd.sv
// Summary of operation
// - Interrupt request drives interrupt pin low 100 us
// - Interrupt request answer echoes code plus flags
// - Interrupt request itself never sets pending flag
// - Soft reset restores power-on state except ground-switch synchronisers and answer word
// - After reset fault summary and pending flag high
// - First valid frame after reset returns ground status
// - Fault summary holds until fault status read
// - Soft reset answer code 0011_1110 with ground inputs
// - Bad address or bit count sets frame error
// - Pending flag set by events, cleared by reads and by the first valid frame after reset
`timescale 1ns/1ps
module irs_cmd #(
  parameter int PULSE_CYCLES = irs_pkg::PULSE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic int_n_out,
  input wire logic [irs_pkg::SG_COUNT-1:0] ground_switch_inputs_in,
  input wire logic cos_event_in,
  input wire logic ext_status_event_in,
  input wire logic [irs_pkg::FAULT_EV_W-1:0] fault_event_in
);

  localparam int PW = $clog2(PULSE_CYCLES + 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES);

  // =====================================================================
  // Link side: runs on the master's clock, framed by chip select
  // =====================================================================
  logic [irs_pkg::CNT_W-1:0] link_cnt;
  logic link_fresh;
  logic [irs_pkg::FRAME_BITS-1:0] link_rx;
  logic [irs_pkg::FRAME_BITS-1:0] link_tx;
  logic [irs_pkg::FRAME_BITS-1:0] resp_word;

  // Frame start marker: set while chip select is high, dropped by the
  // first clock edge of the next frame
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      link_fresh <= 1'b1;
    end else begin
      link_fresh <= 1'b0;
    end
  end

  // Bit counter restarts on the first edge of a frame, so the length
  // survives chip select rising and the core can judge it afterwards.
  // Limitation: a frame with no clock edge leaves the old count and word.
  always_ff @(posedge sclk_in) begin
    if (link_fresh) begin
      link_cnt <= irs_pkg::CNT_W'(1);
    end else if (link_cnt != '1) begin
      link_cnt <= link_cnt + 1'b1; // Saturates so long frames stay bad
    end
  end

  // Shift registers; answer word is loaded on the first edge of a frame
  always_ff @(posedge sclk_in) begin
    link_rx <= {link_rx[irs_pkg::FRAME_BITS-2:0], mosi_in};
    if (link_fresh) begin
      link_tx <= {resp_word[irs_pkg::FRAME_BITS-2:0], 1'b0};
    end else begin
      link_tx <= {link_tx[irs_pkg::FRAME_BITS-2:0], 1'b0};
    end
  end

  // First bit comes straight from the held answer, before any edge
  assign miso_out = link_fresh ? resp_word[irs_pkg::FRAME_BITS-1]
                               : link_tx[irs_pkg::FRAME_BITS-1];
  assign miso_oe_out = ~cs_n_in;

  // =====================================================================
  // Core side state
  // =====================================================================
  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic [irs_pkg::SG_COUNT-1:0] sg_meta;
    logic [irs_pkg::SG_COUNT-1:0] sg_sync;
    logic int_flag;
    logic por_flag;
    logic por_first;
    logic spi_err;
    logic [irs_pkg::FAULT_EV_W-1:0] fault_lat;
    logic [irs_pkg::FRAME_BITS-1:0] resp;
    logic [PW-1:0] pulse_cnt;
    logic int_low;
  } irs_state_s;

  irs_state_s s;
  irs_state_s next_s;

  // Power-on image; soft reset reloads the same image
  function automatic irs_state_s por_state();
    irs_state_s r;
    r = '0;
    r.cs_meta = 1'b1;
    r.cs_sync = 1'b1;
    r.cs_prev = 1'b1;
    r.int_flag = 1'b1;
    r.por_flag = 1'b1;
    r.por_first = 1'b1;
    return r;
  endfunction

  // Commands that this device answers to
  function automatic logic known_cmd(input logic [6:0] a, input logic w);
    return ((a == irs_pkg::ADDR_INT_REQ) && w) ||
           ((a == irs_pkg::ADDR_SOFT_RESET) && w) ||
           ((a == irs_pkg::ADDR_FAULT_READ) && !w) ||
           ((a == irs_pkg::ADDR_SG_READ) && !w);
  endfunction

  function automatic logic fault_sum(input irs_state_s x);
    return x.por_flag | x.spi_err | (|x.fault_lat);
  endfunction

  // Ground-switch status word, also the answer after any reset
  function automatic logic [31:0] sg_word(input irs_state_s x);
    return {irs_pkg::CODE_SG_RESP, fault_sum(x), x.int_flag, 1'b0,
            x.sg_sync};
  endfunction

  // =====================================================================
  // Next-state logic
  // =====================================================================
  logic frame_end;
  logic [6:0] cmd_addr;
  logic cmd_write;
  logic frame_ok;
  logic clr_int;
  logic clr_fault;
  logic err_now;
  logic do_reset;

  // Link word and count are quiet once chip select is seen high twice
  assign frame_end = s.cs_sync & ~s.cs_prev;
  assign cmd_addr = link_rx[irs_pkg::FRAME_BITS-1:irs_pkg::POS_ADDR_LSB];
  assign cmd_write = link_rx[irs_pkg::POS_WRITE];
  assign frame_ok = (link_cnt == irs_pkg::CNT_W'(irs_pkg::FRAME_BITS)) &&
                    known_cmd(cmd_addr, cmd_write);

  always_comb begin
    next_s = s;
    clr_int = 1'b0;
    clr_fault = 1'b0;
    err_now = 1'b0;
    do_reset = 1'b0;
    next_s.cs_meta = cs_n_in;
    next_s.cs_sync = s.cs_meta;
    next_s.cs_prev = s.cs_sync;
    next_s.sg_meta = ground_switch_inputs_in;
    next_s.sg_sync = s.sg_meta;
    if (s.pulse_cnt != '0) begin
      next_s.pulse_cnt = s.pulse_cnt - 1'b1;
    end
    // Data field is never looked at for these commands
    if (frame_end) begin
      if (!frame_ok) begin
        err_now = 1'b1;
        next_s.resp = {link_rx[31:24], fault_sum(s), s.int_flag, 22'h0};
      end else begin
        if (s.por_first) begin
          next_s.por_first = 1'b0;
          clr_int = 1'b1;
        end
        unique case (cmd_addr)
          irs_pkg::ADDR_INT_REQ: begin
            next_s.pulse_cnt = PULSE_LOAD;
            next_s.resp = {irs_pkg::CODE_INT_RESP, fault_sum(s),
                           s.int_flag, 22'h0};
          end
          irs_pkg::ADDR_SOFT_RESET: begin
            do_reset = 1'b1;
          end
          irs_pkg::ADDR_FAULT_READ: begin
            next_s.resp = {irs_pkg::CODE_FAULT_RESP, 1'b0, s.int_flag,
                           11'h0, s.spi_err, 2'b00, s.fault_lat,
                           s.por_flag};
            clr_fault = 1'b1;
            clr_int = 1'b1;
          end
          default: begin
            next_s.resp = sg_word(s);
            clr_int = 1'b1;
          end
        endcase
      end
    end
    // Sticky flags: a new event in the clearing cycle wins
    next_s.int_flag = (s.int_flag & ~clr_int) | cos_event_in |
                      ext_status_event_in;
    next_s.spi_err = (s.spi_err & ~clr_fault) | err_now;
    next_s.por_flag = s.por_flag & ~clr_fault;
    next_s.fault_lat = (s.fault_lat & ~{irs_pkg::FAULT_EV_W{clr_fault}}) |
                       fault_event_in;
    // While the reset answer is pending keep it tracking the inputs
    if (s.por_first && s.cs_sync && !frame_end) begin
      next_s.resp = sg_word(s);
    end
    if (do_reset) begin
      next_s = por_state();
      // Ground-switch synchronisers keep running, so the reset answer is live at once
      next_s.sg_meta = ground_switch_inputs_in;
      next_s.sg_sync = s.sg_meta;
      next_s.resp = sg_word(next_s);
    end
    next_s.int_low = (next_s.pulse_cnt != '0);
  end

  // Single state register, synchronous reset
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s <= por_state();
    end else begin
      s <= next_s;
    end
  end

  // Held answer is only written while the synchronised chip select is high
  assign resp_word = s.resp;
  assign int_n_out = ~s.int_low;

endmodule // irs_cmd

// File: irs_pkg.sv
// =====================================================================
// Shared constants for the interrupt-request / soft-reset command path
// =====================================================================
package irs_pkg;

  // =====================================================================
  // Frame layout
  // =====================================================================
  localparam int FRAME_BITS = 32;
  localparam int CNT_W = 6;
  localparam int SG_COUNT = 21;
  localparam int FAULT_EV_W = 7;
  localparam int POS_ADDR_LSB = 25;
  localparam int POS_WRITE = 24;
  localparam int POS_FAULT = 23;
  localparam int POS_INT = 22;
  localparam int POS_SPI_ERR = 10;

  // =====================================================================
  // Command addresses (bits 31..25) and answer codes (bits 31..24)
  // =====================================================================
  localparam logic [6:0] ADDR_SG_READ = 7'h1F;
  localparam logic [6:0] ADDR_FAULT_READ = 7'h21;
  localparam logic [6:0] ADDR_INT_REQ = 7'h23;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h24;
  localparam logic [7:0] CODE_SG_RESP = 8'h3E;
  localparam logic [7:0] CODE_FAULT_RESP = 8'h42;
  localparam logic [7:0] CODE_INT_RESP = 8'h47;

  // =====================================================================
  // Timing
  // =====================================================================
  localparam int CLK_MHZ = 200;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;

endpackage

// File: irs_cmd_properties.sv
`timescale 1ns/1ps
// =====================================
// Pin checks on the pulse and data pins
module irs_cmd_properties #(
  parameter int PULSE_CYCLES = 20000
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic miso_out,
  input wire logic miso_oe_out,
  input wire logic int_n_out
);
  int low_cnt;
  // Counter stands in for a long repetition the tools cannot unroll
  always_ff @(posedge mclk_in) begin
    low_cnt <= (!rst_n_in || int_n_out) ? 0 : low_cnt + 1;
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_int_reset_idle: assert property ($rose(rst_n_in) |-> int_n_out)
    else $error("int pin low out of reset");
  a_fall_after_cs: assert property ($fell(int_n_out) |-> $past(cs_n_in, 3))
    else $error("int pulse without frame end");
  a_pulse_min: assert property ($fell(int_n_out) |-> !int_n_out [*8])
    else $error("int pulse too short");
  a_pulse_exact: assert property ($rose(int_n_out) |-> low_cnt == PULSE_CYCLES)
    else $error("int pulse width wrong");
  a_pulse_cap: assert property (low_cnt <= PULSE_CYCLES)
    else $error("int pulse too long");
  a_oe_on: assert property (!cs_n_in |-> miso_oe_out)
    else $error("data pin not driven");
  a_oe_off: assert property (cs_n_in |-> !miso_oe_out)
    else $error("data pin driven while idle");
  a_miso_hold: assert property (!cs_n_in && $stable(cs_n_in) && $stable(sclk_in)
    |-> $stable(miso_out))
    else $error("data bit moved without clock");
endmodule // irs_cmd_properties

bind irs_cmd irs_cmd_properties #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in),
  .cs_n_in(cs_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
  .int_n_out(int_n_out));

// File: irs_host.sv
`timescale 1ns/1ps
// ===================================
// Link master, clock idle low, 15 ns
module irs_host (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  // Idle levels at time zero
  initial begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    mosi_out = 1'h0;
  end
  // Frame of nb bits, MSB first; extra leading bits are zero, and only
  // the first 32 answer bits are kept; bit read before each rise
  task automatic xfer(input logic [31:0] tx, input int nb,
                      output logic [31:0] rx);
    cs_n_out = 1'h0;
    for (int k = 0; k < nb; k++) begin
      mosi_out = (k < nb - 32) ? 1'h0 : tx[nb - 1 - k];
      #7.5;
      if (k < 32) begin
        rx[31 - k] = miso_oe_in ? miso_in : 1'hX;
      end
      sclk_out = 1'h1;
      #7.5;
      sclk_out = 1'h0;
    end
    #7.5;
    cs_n_out = 1'h1;
    mosi_out = ~mosi_out; // Released line must not keep last bit
  endtask
endmodule // irs_host

// File: irs_cmd_test.sv
`timescale 1ns/1ps
// =================================
// Command sequence through the link
module irs_cmd_test;
  localparam int PW = 40;
  localparam logic [31:0] RSG = {irs_pkg::ADDR_SG_READ, 25'h0};
  localparam logic [31:0] RFL = {irs_pkg::ADDR_FAULT_READ, 25'h0};
  localparam logic [31:0] IRQ = {irs_pkg::ADDR_INT_REQ, 1'h1, 24'hA50000};
  localparam logic [31:0] SRS = {irs_pkg::ADDR_SOFT_RESET, 1'h1, 24'h0};
  localparam logic [20:0] SGV = 21'h1A5C3;
  localparam logic [31:0] G0 = {irs_pkg::CODE_SG_RESP, 3'h4, SGV};
  localparam logic [31:0] G1 = G0 | 32'h00400000;
  localparam logic [31:0] G2 = {irs_pkg::CODE_SG_RESP, 3'h2, SGV};
  // Frame 10 is a 33-bit frame, refused for its bit count
  localparam logic [31:0] TX [13] = '{IRQ, RSG, RFL, 32'hFE000000, RSG,
    RFL, SRS, RSG, RFL, RSG, RSG, RFL, RSG};
  // Answers lag one frame; reads report flags before clearing them
  localparam logic [31:0] EX [13] = '{G1, 32'h47C00000, G0, 32'h42000001,
    32'hFEC00000, G1, 32'h420004FE, G1, G1, 32'h42000001, G2,
    32'h3E000000, 32'h42000400};
  logic mclk_in, rst_n_in, sclk, cs_n, mosi, miso, miso_oe, int_n;
  logic cos = 1'h0;
  logic ext = 1'h0;
  logic [irs_pkg::FAULT_EV_W-1:0] fev = '0;
  logic [31:0] rx;
  int n_errors = 0;
  int total_checks = 0;
  int low;
  irs_cmd #(.PULSE_CYCLES(PW)) dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
    .miso_oe_out(miso_oe), .int_n_out(int_n), .ground_switch_inputs_in(SGV),
    .cos_event_in(cos), .ext_status_event_in(ext), .fault_event_in(fev));
  irs_host host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .miso_oe_in(miso_oe));
  // Core clock, 5 ns
  initial begin
    mclk_in = 1'h0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic check(input string w, input logic [31:0] e, s);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, well past the expected run length
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
  // Frames spaced well over the minimum idle gap
  initial begin
    rst_n_in = 1'h0;
    repeat (12) @(posedge mclk_in);
    #1 rst_n_in = 1'h1;
    for (int i = 0; i < 13; i++) begin
      repeat (6) @(posedge mclk_in);
      #1;
      // One-cycle events: switch change and faults, later extended status
      if (i == 3 || i == 9) begin
        cos = (i == 3);
        ext = (i == 9);
        fev = {irs_pkg::FAULT_EV_W{i == 3}};
        @(posedge mclk_in);
        #1;
        cos = 1'h0;
        ext = 1'h0;
        fev = '0;
      end
      host.xfer(TX[i], (i == 10) ? 33 : 32, rx);
      check("answer", EX[i], rx);
      if (i == 0) begin
        low = 0;
        for (int k = 0; k < 99 && (low == 0 || int_n === 1'h0); k++) begin
          @(posedge mclk_in);
          #1;
          if (int_n === 1'h0) low++;
        end
        check("pulse", 32'(PW), 32'(low));
      end
    end
    test_done();
  end
endmodule // irs_cmd_test
